// ---- inc/eerwc_pkg.sv ----
package eerwc_pkg;

	// ----------------------------------------------------------------
	// data space map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR   = 8'hdf;
	localparam logic [7:0] BANK_ADDR   = 8'hcb;
	localparam logic [7:0] WIN_LIMIT   = 8'h40;
	localparam logic [7:0] BANK_PAGE0  = 8'h01;
	localparam logic [7:0] BANK_PAGE1  = 8'h02;
	localparam logic [7:0] BANK_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// control register layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam int         BIT_STANDBY = 6;
	localparam int         BIT_START   = 3;
	localparam int         BIT_ROW     = 2;
	localparam int         BIT_BUSY    = 1;
	localparam int         BIT_ENA     = 0;
	localparam logic [7:0] BUSY_READ   = 8'h02;

	// ----------------------------------------------------------------
	// array geometry and contents
	// ----------------------------------------------------------------
	localparam int         EE_BYTES    = 128;
	localparam int         ROW_BYTES   = 8;
	localparam logic [7:0] ERASED      = 8'hff;
	localparam logic [7:0] BAD_READ    = 8'h00;

	// ----------------------------------------------------------------
	// programming time
	// ----------------------------------------------------------------
	localparam int PROG_TIME_NS  = 5000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		EERWC_IDLE      = 2'b00,
		EERWC_BYTE_PROG = 2'b01,
		EERWC_ROW_PROG  = 2'b10
	} eerwc_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} eerwc_req_t;

	typedef struct packed {
		logic [EE_BYTES-1:0][7:0]  mem;
		logic [ROW_BYTES-1:0][7:0] latch;
		logic [ROW_BYTES-1:0]      mask;
		logic [3:0]                row;
		logic                      row_valid;
		logic                      row_mode;
		logic                      row_start;
		logic                      ena;
		logic                      standby;
		logic [7:0]                bank;
		eerwc_phase_t              phase;
		logic [15:0]               cnt;
		logic [6:0]                baddr;
		logic [7:0]                bdata;
		logic [7:0]                rdata;
		logic                      busy;
	} eerwc_state_t;

endpackage : eerwc_pkg

// ---- logic/eerwc_ctrl.sv ----
`timescale 1ns/1ps
// What this block does, and what software must do (RL15-RL17)
// [RL1] row mode set captures row address until end
// [RL2] other rows give erroneous results in row mode
// [RL3] row mode set clears eight row latches
// [RL4] start programs only written row bytes
// [RL5] row mode self-clears after row programming
// [RL6] start ignored unless enable and row mode
// [RL7] control at DFh, reset 00h, fixed bits
// [RL8] standby disables array, accesses meaningless
// [RL9] start bit self-clears when programming completes
// [RL10] row is page bit plus A5-A3, byte by A2-A0
// [RL11] clearing row mode early abandons, array untouched
// [RL12] busy set while programming runs
// [RL13] accesses during busy aborted, cycle completes
// [RL14] write without enable starts no cycle
// [RL15] software must not read in row mode
// [RL16] software polls busy before each access
// [RL17] software avoids read-modify on control register
// [RL18] array starts erased, all bytes FFh
// [RL19] busy locks control writes, only busy reads
// [RL20] byte mode writes one byte per cycle
// [RL21] bank 01h/02h maps page into 00h-3Fh
// [RL22] enabled byte write starts cycle, raises busy
module eerwc_ctrl
	import eerwc_pkg::*;
#(
	parameter int PROG_CYCLES = eerwc_pkg::PROG_CYCLES
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// cpu data space access
	input  wire eerwc_pkg::eerwc_req_t req,
	output logic [7:0]             cpu_rdata,
	// status
	output logic                   prog_busy_flag,
	output logic                   array_standby,
	output logic                   row_mode_enable
);
	import eerwc_pkg::*;

	localparam int PROG_LAST = PROG_CYCLES - 1;

	eerwc_state_t q, d;

	logic       bank_ok;
	logic       in_win;
	logic       ee_acc;
	logic [6:0] ee_idx;
	logic [3:0] ee_row;
	logic       ctrl_wr;
	logic       ee_wr;
	logic       row_ok;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign bank_ok = (q.bank == BANK_PAGE0) || (q.bank == BANK_PAGE1); // RL21
	assign in_win  = (req.addr < WIN_LIMIT) && bank_ok;
	assign ee_idx  = {q.bank == BANK_PAGE1, req.addr[5:0]};
	assign ee_row  = ee_idx[6:3]; // RL10
	// standby and busy both make the array unreachable
	assign ee_acc  = in_win && !q.standby && !q.busy; // RL8 RL13
	assign row_ok  = !q.row_valid || (ee_row == q.row); // RL2
	assign ctrl_wr = req.wr && (req.addr == CTRL_ADDR);
	assign ee_wr   = req.wr && ee_acc;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d       = q;
		d.rdata = BAD_READ;

		if (req.wr && (req.addr == BANK_ADDR)) begin
			d.bank = req.wdata; // RL21
		end

		if (req.rd) begin
			if (req.addr == CTRL_ADDR) begin
				// write-only bits never read back
				d.rdata = q.busy ? BUSY_READ : 8'h00; // RL19 RL7
			end else if (in_win && ee_acc && row_ok) begin
				d.rdata = q.mem[ee_idx];
			end
		end

		// control writes are locked out while a cycle runs
		if (ctrl_wr && !q.busy) begin // RL19
			d.standby = req.wdata[BIT_STANDBY]; // RL8
			d.ena     = req.wdata[BIT_ENA];
			if (req.wdata[BIT_ROW] && !q.row_mode) begin
				d.row_mode  = 1'b1; // RL1
				d.row_valid = 1'b0;
				d.mask      = '0; // RL3
				d.latch     = '0; // RL3
			end else if (!req.wdata[BIT_ROW] && q.row_mode) begin
				d.row_mode  = 1'b0; // RL11
				d.row_valid = 1'b0;
				d.mask      = '0;
			end
			if (req.wdata[BIT_START] && req.wdata[BIT_ROW] && q.ena && q.row_mode) begin
				d.row_start = 1'b1; // RL6
				d.busy      = 1'b1; // RL12
				d.phase     = EERWC_ROW_PROG;
				d.cnt       = '0;
			end
		end

		if (ee_wr) begin
			if (q.row_mode) begin
				// the first write fixes the row until the cycle ends
				if (row_ok) begin
					d.row_valid                = 1'b1; // RL1
					d.row                      = ee_row; // RL1
					d.latch[req.addr[2:0]]     = req.wdata;
					d.mask[req.addr[2:0]]      = 1'b1; // RL4
				end
			end else if (q.ena) begin // RL14
				d.busy  = 1'b1; // RL22
				d.phase = EERWC_BYTE_PROG; // RL20
				d.baddr = ee_idx;
				d.bdata = req.wdata;
				d.cnt   = '0;
			end
		end

		unique case (q.phase)
			EERWC_IDLE: begin
			end
			EERWC_BYTE_PROG, EERWC_ROW_PROG: begin
				d.cnt = q.cnt + 16'h0001;
				if (q.cnt == 16'(PROG_LAST)) begin
					if (q.phase == EERWC_BYTE_PROG) begin
						d.mem[q.baddr] = q.bdata; // RL20
					end else begin
						for (int i = 0; i < ROW_BYTES; i++) begin
							if (q.mask[i]) begin
								d.mem[{q.row, 3'(i)}] = q.latch[i]; // RL4
							end
						end
						d.row_mode  = 1'b0; // RL5
						d.row_start = 1'b0; // RL9
						d.row_valid = 1'b0;
						d.mask      = '0;
					end
					d.busy  = 1'b0; // RL12
					d.phase = EERWC_IDLE;
					d.cnt   = '0;
				end
			end
			default: begin
				d.phase = EERWC_IDLE;
				d.busy  = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q       <= '0; // RL7
			q.bank  <= BANK_RESET;
			q.mem   <= {EE_BYTES{ERASED}}; // RL18
		end else begin
			q <= d;
		end
	end

	assign cpu_rdata       = q.rdata;
	assign prog_busy_flag  = q.busy;
	assign array_standby   = q.standby;
	assign row_mode_enable = q.row_mode;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	a_busy_holds: assert property ($rose(q.busy) |-> ##PROG_LAST q.busy) // RL12
		else $error("busy dropped before the programming time");
	a_busy_ends: assert property ($rose(q.busy) |-> ##PROG_CYCLES !q.busy) // RL12
		else $error("busy did not drop after the programming time");
	a_start_gated: assert property (
		ctrl_wr && !q.busy && req.wdata[BIT_START] && !(q.ena && q.row_mode)
		|=> !q.row_start && !q.busy) // RL6
		else $error("row start accepted without enable and row mode");
	a_row_latch_clr: assert property (
		ctrl_wr && !q.busy && !q.row_mode && req.wdata[BIT_ROW]
		|=> q.row_mode && (q.mask == '0) && (q.latch == '0)) // RL3
		else $error("row latches not cleared on row mode entry");
	a_row_selfclr: assert property (
		$fell(q.busy) && ($past(q.phase) == EERWC_ROW_PROG)
		|-> !q.row_mode && !q.row_start) // RL5 RL9
		else $error("row mode or start bit left set after row cycle");
	a_ctrl_locked: assert property (
		q.busy && ctrl_wr
		|=> (q.ena == $past(q.ena)) && (q.standby == $past(q.standby))) // RL19
		else $error("control register changed while busy");
	a_no_enable: assert property (
		ee_wr && !q.ena && !q.row_mode |=> !q.busy) // RL14
		else $error("write cycle started without program enable");
	a_byte_start: assert property (
		ee_wr && q.ena && !q.row_mode |=> q.busy && (q.bdata == $past(req.wdata))) // RL22
		else $error("enabled byte write did not start a cycle");
	// the final busy cycle clears the row mask on purpose, so it is left out here
	a_busy_abort: assert property (
		q.busy && req.wr && in_win && (q.cnt != 16'(PROG_LAST))
		|=> (q.bdata == $past(q.bdata)) && (q.mask == $past(q.mask))) // RL13
		else $error("array write taken while busy");
	a_abandon: assert property (
		ctrl_wr && !q.busy && q.row_mode && !req.wdata[BIT_ROW]
		|=> !q.row_mode && !q.busy && (q.mem == $past(q.mem))) // RL11
		else $error("abandoned row operation touched the array");
	a_standby_read: assert property (
		req.rd && in_win && q.standby |=> cpu_rdata == BAD_READ) // RL8
		else $error("array read returned data in standby");
	a_wrong_row: assert property (
		req.wr && ee_acc && q.row_mode && !row_ok |=> q.mask == $past(q.mask)) // RL2
		else $error("write to another row was latched");

	// ----------------------------------------------------------------
	// read path checks
	// ----------------------------------------------------------------
	// write-only bits must never leak into a control read
	a_ctrl_busy_rd: assert property (
		req.rd && (req.addr == CTRL_ADDR) && q.busy |=> cpu_rdata == BUSY_READ) // RL19
		else $error("control read while busy did not show busy only");
	a_ctrl_idle_rd: assert property (
		req.rd && (req.addr == CTRL_ADDR) && !q.busy |=> cpu_rdata == 8'h00) // RL7
		else $error("control read while idle was not zero");
	a_nobank_rd: assert property (
		req.rd && (req.addr < WIN_LIMIT) && !bank_ok |=> cpu_rdata == BAD_READ) // RL21
		else $error("array read without a mapped page returned data");
	a_busy_rd: assert property (
		req.rd && in_win && q.busy |=> cpu_rdata == BAD_READ) // RL13
		else $error("array read while busy returned data");
	a_other_row_rd: assert property (
		req.rd && in_win && q.row_valid && (ee_row != q.row) |=> cpu_rdata == BAD_READ) // RL2
		else $error("read of another row returned data in row mode");

	// ----------------------------------------------------------------
	// programming cycle checks
	// ----------------------------------------------------------------
	a_busy_phase: assert property (
		q.busy == (q.phase != EERWC_IDLE)) // RL12
		else $error("busy flag and programming phase disagree");
	a_cnt_bound: assert property (
		q.busy |-> q.cnt <= 16'(PROG_LAST)) // RL12
		else $error("programming counter ran past its last cycle");
	a_byte_lands: assert property (
		$fell(q.busy) && ($past(q.phase) == EERWC_BYTE_PROG)
		|-> q.mem[$past(q.baddr)] == $past(q.bdata)) // RL20
		else $error("byte cycle ended without writing its byte");
	// the array may only change at the end of a programming cycle
	a_mem_quiet: assert property (
		!q.busy |=> q.mem == $past(q.mem)) // RL14
		else $error("array changed outside a programming cycle");
	a_start_in_row: assert property (
		q.row_start |-> q.row_mode && q.busy) // RL6
		else $error("row start set outside a running row cycle");
	a_row_busy_lock: assert property (
		q.busy && (q.cnt != 16'(PROG_LAST)) |=> q.row_mode == $past(q.row_mode)) // RL19
		else $error("row mode changed in the middle of a cycle");

	// ----------------------------------------------------------------
	// row and write gating checks
	// ----------------------------------------------------------------
	a_row_fixed: assert property (
		q.row_valid |=> !q.row_valid || (q.row == $past(q.row))) // RL1
		else $error("captured row address moved");
	a_row_entry_clr: assert property (
		$rose(q.row_mode) |-> (q.mask == '0) && !q.row_valid) // RL3
		else $error("row mode entered with stale latches");
	a_row_no_byte: assert property (
		ee_wr && q.row_mode |=> !q.busy) // RL4
		else $error("row mode write started a programming cycle");
	a_standby_wr: assert property (
		req.wr && in_win && q.standby && !q.busy
		|=> !q.busy && (q.mask == $past(q.mask))) // RL8
		else $error("array write taken in standby");
	a_nobank_wr: assert property (
		req.wr && (req.addr < WIN_LIMIT) && !bank_ok && !q.busy
		|=> !q.busy && (q.mask == $past(q.mask))) // RL21
		else $error("array write taken without a mapped page");
	a_standby_load: assert property (
		ctrl_wr && !q.busy |=> q.standby == $past(req.wdata[BIT_STANDBY])) // RL8
		else $error("standby bit not loaded by a control write");
	a_ena_load: assert property (
		ctrl_wr && !q.busy |=> q.ena == $past(req.wdata[BIT_ENA])) // RL14
		else $error("program enable not loaded by a control write");

	c_byte_prog: cover property ($fell(q.busy) && ($past(q.phase) == EERWC_BYTE_PROG));
	c_row_prog: cover property ($fell(q.busy) && ($past(q.phase) == EERWC_ROW_PROG));
	c_abandon: cover property (ctrl_wr && !q.busy && q.row_mode && !req.wdata[BIT_ROW]);
	c_busy_poll: cover property (req.rd && (req.addr == CTRL_ADDR) && q.busy);
	c_standby: cover property (ctrl_wr && !q.busy && req.wdata[BIT_STANDBY]);

endmodule : eerwc_ctrl

// ---- dv/eerwc_cpu_model.sv ----
`timescale 1ns/1ps
module eerwc_cpu_model
	import eerwc_pkg::*;
(
	// clock
	input  wire logic             mclk,
	// requests toward the block
	output eerwc_pkg::eerwc_req_t req,
	// answers from the block
	input  wire logic [7:0]       cpu_rdata,
	input  wire logic             prog_busy_flag
);
	import eerwc_pkg::*;

	initial req = '0;

	// ----------------------------------------------------------------
	// accesses: called on a falling edge, one idle cycle after each
	// ----------------------------------------------------------------
	// control register is only ever written whole, never read-modified
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge mclk);
		req <= '0;
		@(negedge mclk);
	endtask : wr

	// caller never reads the array while row mode is set
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge mclk);
		req <= '0;
		d = cpu_rdata;
		@(negedge mclk);
	endtask : rd

	// bounded so a stuck busy cannot hang the caller
	task automatic poll_idle();
		for (int i = 0; i < 400 && prog_busy_flag !== 1'b0; i++) begin
			@(negedge mclk);
		end
		// one more edge so pulse bookkeeping on this edge has settled
		@(negedge mclk);
	endtask : poll_idle

endmodule : eerwc_cpu_model

// ---- dv/tb_eerwc_ctrl.sv ----
`timescale 1ns/1ps
module tb_eerwc_ctrl;
	import eerwc_pkg::*;

	localparam int P = 12;

	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	eerwc_req_t req;
	logic [7:0] cpu_rdata;
	logic       prog_busy_flag;
	logic       array_standby;
	logic       row_mode_enable;
	int         num_errors = 0;
	int         checks = 0;
	int         cycles = 0;
	logic [7:0] run = '0;
	logic [7:0] last_run = '0;

	always #12.5 mclk = ~mclk;

	eerwc_ctrl #(.PROG_CYCLES(P)) dut (.mclk(mclk), .nrst(nrst), .req(req),
		.cpu_rdata(cpu_rdata), .prog_busy_flag(prog_busy_flag),
		.array_standby(array_standby), .row_mode_enable(row_mode_enable));

	eerwc_cpu_model cpu (.mclk(mclk), .req(req), .cpu_rdata(cpu_rdata),
		.prog_busy_flag(prog_busy_flag));

	// length of the most recent busy pulse, in cycles
	always @(negedge mclk) begin
		if (prog_busy_flag === 1'b1) begin
			run <= run + 8'h01;
		end else if (run != 8'h00) begin
			last_run <= run;
			run <= 8'h00;
		end
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask : check1

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.rd(a, d);
		check8(d, exp);
	endtask : rchk

	initial begin
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		rchk(CTRL_ADDR, 8'h00);
		rchk(8'h05, 8'h00);
		cpu.wr(BANK_ADDR, 8'h01);
		rchk(8'h05, 8'hff);
		cpu.wr(8'h05, 8'h5a);
		check1(prog_busy_flag, 1'b0);
		// byte mode, then poke at the block while it is busy
		cpu.wr(CTRL_ADDR, 8'h01);
		cpu.wr(8'h05, 8'ha5);
		check1(prog_busy_flag, 1'b1);
		rchk(CTRL_ADDR, BUSY_READ);
		cpu.wr(CTRL_ADDR, 8'h40);
		cpu.wr(8'h05, 8'h00);
		rchk(8'h05, 8'h00);
		cpu.poll_idle();
		check8(last_run, 8'(P));
		check1(array_standby, 1'b0);
		rchk(8'h05, 8'ha5);
		rchk(8'h06, 8'hff);
		// abandoned row attempt must leave no trace
		cpu.wr(CTRL_ADDR, 8'h05);
		check1(row_mode_enable, 1'b1);
		cpu.wr(8'h19, 8'h77);
		cpu.wr(CTRL_ADDR, 8'h01);
		check1(row_mode_enable, 1'b0);
		rchk(8'h19, 8'hff);
		// partial row write, plus a stray write to another row
		cpu.wr(CTRL_ADDR, 8'h05);
		cpu.wr(8'h18, 8'h11);
		cpu.wr(8'h1a, 8'h22);
		cpu.wr(8'h1b, 8'h33);
		cpu.wr(8'h21, 8'h44);
		cpu.wr(CTRL_ADDR, 8'h0d);
		cpu.poll_idle();
		check8(last_run, 8'(P));
		check1(row_mode_enable, 1'b0);
		rchk(8'h18, 8'h11);
		rchk(8'h1a, 8'h22);
		rchk(8'h1b, 8'h33);
		rchk(8'h19, 8'hff);
		rchk(8'h21, 8'hff);
		cpu.wr(CTRL_ADDR, 8'h09);
		check1(prog_busy_flag, 1'b0);
		rchk(CTRL_ADDR, 8'h00);
		cpu.wr(CTRL_ADDR, 8'h40);
		check1(array_standby, 1'b1);
		rchk(8'h18, 8'h00);
		cpu.wr(CTRL_ADDR, 8'h00);
		rchk(8'h18, 8'h11);
		cpu.wr(BANK_ADDR, 8'h02);
		rchk(8'h18, 8'hff);
		conclude();
	end

endmodule : tb_eerwc_ctrl
